/* File: fabric_loopback_path.sv */
// Port datapath steering between switch fabric and network side.
// Assumes nibble-wide transmit and receive streams synchronous to sys_clk.
`timescale 1ns/1ps
module fabric_loopback_path
  import port_ctrl_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    loopback_enable,
  input  wire logic                    collision_test_enable,
  input  wire logic                    power_down,
  input  wire logic                    fab_tx_en,
  input  wire logic [NIBBLE_WIDTH-1:0] fab_txd,
  input  wire logic                    net_rx_dv,
  input  wire logic [NIBBLE_WIDTH-1:0] net_rxd,
  input  wire logic                    net_col,
  output logic                         net_tx_en,
  output logic [NIBBLE_WIDTH-1:0]      net_txd,
  output logic                         fab_rx_dv,
  output logic [NIBBLE_WIDTH-1:0]      fab_rxd,
  output logic                         fab_col
);

  typedef struct packed {
    logic                    net_tx_en;
    logic [NIBBLE_WIDTH-1:0] net_txd;
    logic                    fab_rx_dv;
    logic [NIBBLE_WIDTH-1:0] fab_rxd;
    logic                    fab_col;
  } path_state_type;

  path_state_type path_reg;
  path_state_type path_next;

  always_comb begin
    path_next = path_reg;
    if (loopback_enable) begin
      path_next.net_tx_en = 1'b0;
      path_next.net_txd   = '0;
      path_next.fab_rx_dv = fab_tx_en;
      path_next.fab_rxd   = fab_txd;
    end else begin
      path_next.net_tx_en = fab_tx_en && !power_down;
      path_next.net_txd   = power_down ? '0 : fab_txd;
      path_next.fab_rx_dv = net_rx_dv && !power_down;
      path_next.fab_rxd   = net_rxd;
    end
    // Test collision follows transmit activity; a real one only when on the wire.
    path_next.fab_col = (collision_test_enable && fab_tx_en) ||
                        (!loopback_enable && !power_down && net_col);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      path_reg <= '0;
    end else begin
      path_reg <= path_next;
    end
  end

  assign net_tx_en = path_reg.net_tx_en;
  assign net_txd   = path_reg.net_txd;
  assign fab_rx_dv = path_reg.fab_rx_dv;
  assign fab_rxd   = path_reg.fab_rxd;
  assign fab_col   = path_reg.fab_col;

  sequence s_looped_tx;
    loopback_enable && fab_tx_en;
  endsequence

  a_loop_no_network: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_looped_tx |=> !net_tx_en && fab_rx_dv && fab_rxd == $past(fab_txd))
    else $error("Looped transmit data reached the network or missed the fabric.");

  a_collision_test: assert property (@(posedge sys_clk) disable iff (!reset_n)
    collision_test_enable && fab_tx_en |=> fab_col)
    else $error("Collision test mode did not raise collision during transmit.");

endmodule

/* File: mgmt_host.sv */
// Management host model that issues single-cycle register reads and writes.
// Assumes a free-running sys_clk; requests change only at its falling edge.
`timescale 1ns/1ps
module mgmt_host
  import port_ctrl_pkg::*;
(
  input  wire logic                                      sys_clk,
  output logic                                           reg_wr_en,
  output logic                                           reg_rd_en,
  output logic [port_ctrl_pkg::REG_INDEX_WIDTH-1:0]      reg_index,
  output logic [port_ctrl_pkg::REG_DATA_WIDTH-1:0]       reg_wdata
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_index = 5'h1f;
    reg_wdata = 16'h5a5a;
  end

  // Between requests the index and data lines show the inverse of the last
  // request, so that a stale value is never mistaken for a fresh one.
  task automatic access(input logic wr, input logic [4:0] idx, input logic [15:0] d);
    @(negedge sys_clk);
    reg_wr_en <= wr;
    reg_rd_en <= !wr;
    reg_index <= idx;
    reg_wdata <= d;
    @(negedge sys_clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    reg_index <= ~idx;
    reg_wdata <= ~d;
  endtask
endmodule

/* File: port_ctrl_pkg.sv */
// Constants for the per-port transceiver basic control register block.
// Assumes management accesses arrive already decoded as 16-bit register words.
package port_ctrl_pkg;

  localparam int          REG_INDEX_WIDTH      = 5;
  localparam int          REG_DATA_WIDTH       = 16;
  localparam int          NIBBLE_WIDTH         = 4;

  localparam logic [4:0]  CTRL_INDEX           = 5'h00;
  localparam logic [4:0]  STATUS_INDEX         = 5'h01;

  localparam int          SOFT_RESET_BIT       = 15;
  localparam int          LOOPBACK_BIT         = 14;
  localparam int          SPEED_BIT            = 13;
  localparam int          AUTONEG_BIT          = 12;
  localparam int          POWER_DOWN_BIT       = 11;
  localparam int          RESTART_BIT          = 9;
  localparam int          DUPLEX_BIT           = 8;
  localparam int          COLLISION_TEST_BIT   = 7;
  localparam int          STATUS_AN_DONE_BIT   = 5;

  localparam logic        LOOPBACK_RESET       = 1'b0;
  localparam logic        POWER_DOWN_RESET     = 1'b0;
  localparam logic        RESTART_RESET        = 1'b0;
  localparam logic        COLLISION_TEST_RESET = 1'b0;
  localparam logic        SOFT_RESET_RESET     = 1'b0;
  localparam logic [15:0] REG_WORD_RESET       = 16'h0000;

endpackage

/* File: port_transceiver_control.sv */
// Basic control register of one switch port transceiver, with its effects.
// Assumes the management engine presents decoded register reads and writes.
// Straps are static levels; they are captured at the first edge after reset.
//
// Behaviour
// - Loopback returns fabric transmit data to fabric.
// - Speed bit forces 10 or 100 without negotiation.
// - Negotiation enable overrides forced speed and duplex.
// - Power-down bit stops network side only; loopback and test collision keep running; clearing allows negotiation.
// - Restart bit restarts negotiation, then self-clears.
// - Duplex bit forces half or full without negotiation.
// - Collision test drives collision during transmission.
// - Speed default is negotiation strap OR speed strap.
// - Soft reset bit restores defaults, then self-clears.
// - Negotiation enable default equals negotiation strap.
// - Duplex default is NOT negotiation strap AND duplex.
`timescale 1ns/1ps
module port_transceiver_control
  import port_ctrl_pkg::*;
(
  input  wire logic                                   sys_clk,
  input  wire logic                                   reset_n,
  input  wire logic                                   autoneg_strap,
  input  wire logic                                   speed_strap,
  input  wire logic                                   duplex_strap,
  input  wire logic                                   reg_wr_en,
  input  wire logic                                   reg_rd_en,
  input  wire logic [port_ctrl_pkg::REG_INDEX_WIDTH-1:0] reg_index,
  input  wire logic [port_ctrl_pkg::REG_DATA_WIDTH-1:0]  reg_wdata,
  input  wire logic                                   autoneg_done,
  input  wire logic                                   an_speed_100,
  input  wire logic                                   an_full_duplex,
  input  wire logic                                   fab_tx_en,
  input  wire logic [port_ctrl_pkg::NIBBLE_WIDTH-1:0]    fab_txd,
  input  wire logic                                   net_rx_dv,
  input  wire logic [port_ctrl_pkg::NIBBLE_WIDTH-1:0]    net_rxd,
  input  wire logic                                   net_col,
  output logic [port_ctrl_pkg::REG_DATA_WIDTH-1:0]       reg_rdata,
  output logic                                        reg_rd_valid,
  output logic                                        autoneg_enable,
  output logic                                        autoneg_restart_pulse,
  output logic                                        autoneg_complete,
  output logic                                        port_power_down,
  output logic                                        port_speed_100,
  output logic                                        port_full_duplex,
  output logic                                        net_tx_en,
  output logic [port_ctrl_pkg::NIBBLE_WIDTH-1:0]         net_txd,
  output logic                                        fab_rx_dv,
  output logic [port_ctrl_pkg::NIBBLE_WIDTH-1:0]         fab_rxd,
  output logic                                        fab_col
);

  import port_ctrl_pkg::*;

  typedef struct packed {
    logic                      loaded;
    logic                      soft_rst;
    logic                      loopback;
    logic                      speed;
    logic                      an;
    logic                      pd;
    logic                      restart;
    logic                      duplex;
    logic                      col_test;
    logic                      an_complete;
    logic                      eff_speed;
    logic                      eff_duplex;
    logic [REG_DATA_WIDTH-1:0] rdata;
    logic                      rd_valid;
  } ctrl_state_type;

  ctrl_state_type            ctrl_reg;
  ctrl_state_type            ctrl_next;
  logic                      ctrl_wr;
  logic                      def_speed;
  logic                      def_an;
  logic                      def_duplex;
  logic [REG_DATA_WIDTH-1:0] ctrl_word;
  logic [REG_DATA_WIDTH-1:0] status_word;

  assign ctrl_wr    = reg_wr_en && reg_index == CTRL_INDEX;
  assign def_speed  = autoneg_strap | speed_strap;
  assign def_an     = autoneg_strap;
  assign def_duplex = !autoneg_strap & duplex_strap;

  always_comb begin
    ctrl_word                     = REG_WORD_RESET;
    ctrl_word[SOFT_RESET_BIT]     = ctrl_reg.soft_rst;
    ctrl_word[LOOPBACK_BIT]       = ctrl_reg.loopback;
    ctrl_word[SPEED_BIT]          = ctrl_reg.speed;
    ctrl_word[AUTONEG_BIT]        = ctrl_reg.an;
    ctrl_word[POWER_DOWN_BIT]     = ctrl_reg.pd;
    ctrl_word[RESTART_BIT]        = ctrl_reg.restart;
    ctrl_word[DUPLEX_BIT]         = ctrl_reg.duplex;
    ctrl_word[COLLISION_TEST_BIT] = ctrl_reg.col_test;
    status_word                     = REG_WORD_RESET;
    status_word[STATUS_AN_DONE_BIT] = ctrl_reg.an_complete;
  end

  always_comb begin
    ctrl_next          = ctrl_reg;
    ctrl_next.soft_rst = 1'b0;
    ctrl_next.restart  = 1'b0;
    ctrl_next.rd_valid = 1'b0;
    if (!ctrl_reg.loaded || (ctrl_wr && reg_wdata[SOFT_RESET_BIT])) begin
      // First edge after chip reset, or a soft reset: strap-derived defaults.
      ctrl_next.loaded   = 1'b1;
      ctrl_next.soft_rst = ctrl_reg.loaded;
      ctrl_next.loopback = LOOPBACK_RESET;
      ctrl_next.speed    = def_speed;
      ctrl_next.an       = def_an;
      ctrl_next.pd       = POWER_DOWN_RESET;
      ctrl_next.restart  = RESTART_RESET;
      ctrl_next.duplex   = def_duplex;
      ctrl_next.col_test = COLLISION_TEST_RESET;
    end else if (ctrl_wr) begin
      // Bits 10 and 6..0 are simply not stored.
      ctrl_next.loopback = reg_wdata[LOOPBACK_BIT];
      ctrl_next.speed    = reg_wdata[SPEED_BIT];
      ctrl_next.an       = reg_wdata[AUTONEG_BIT];
      ctrl_next.pd       = reg_wdata[POWER_DOWN_BIT];
      ctrl_next.restart  = reg_wdata[RESTART_BIT];
      ctrl_next.duplex   = reg_wdata[DUPLEX_BIT];
      ctrl_next.col_test = reg_wdata[COLLISION_TEST_BIT];
    end
    // A restart, disabled negotiation or power-down voids the completion.
    if (ctrl_next.restart || !ctrl_next.an || ctrl_next.pd || ctrl_next.soft_rst) begin
      ctrl_next.an_complete = 1'b0;
    end
    // The engine's report wins over a clear in the same cycle.
    if (autoneg_done && ctrl_reg.an && !ctrl_reg.pd && ctrl_reg.loaded) begin
      ctrl_next.an_complete = 1'b1;
    end
    ctrl_next.eff_speed  = ctrl_reg.an ? an_speed_100 : ctrl_reg.speed;
    ctrl_next.eff_duplex = ctrl_reg.an ? an_full_duplex : ctrl_reg.duplex;
    if (reg_rd_en) begin
      ctrl_next.rd_valid = 1'b1;
      if (reg_index == CTRL_INDEX) begin
        ctrl_next.rdata = ctrl_word;
      end else if (reg_index == STATUS_INDEX) begin
        ctrl_next.rdata = status_word;
      end else begin
        ctrl_next.rdata = REG_WORD_RESET;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign reg_rdata             = ctrl_reg.rdata;
  assign reg_rd_valid          = ctrl_reg.rd_valid;
  assign autoneg_enable        = ctrl_reg.an;
  assign autoneg_restart_pulse = ctrl_reg.restart;
  assign autoneg_complete      = ctrl_reg.an_complete;
  assign port_power_down       = ctrl_reg.pd;
  assign port_speed_100        = ctrl_reg.eff_speed;
  assign port_full_duplex      = ctrl_reg.eff_duplex;

  fabric_loopback_path u_path (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .loopback_enable       (ctrl_reg.loopback),
    .collision_test_enable (ctrl_reg.col_test),
    .power_down            (ctrl_reg.pd),
    .fab_tx_en             (fab_tx_en),
    .fab_txd               (fab_txd),
    .net_rx_dv             (net_rx_dv),
    .net_rxd               (net_rxd),
    .net_col               (net_col),
    .net_tx_en             (net_tx_en),
    .net_txd               (net_txd),
    .fab_rx_dv             (fab_rx_dv),
    .fab_rxd               (fab_rxd),
    .fab_col               (fab_col)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_plain_write;
    ctrl_wr && !reg_wdata[SOFT_RESET_BIT] && ctrl_reg.loaded;
  endsequence

  sequence s_soft_reset_write;
    ctrl_wr && reg_wdata[SOFT_RESET_BIT] && ctrl_reg.loaded;
  endsequence

  a_forced_speed: assert property (!ctrl_reg.an |=> port_speed_100 == $past(ctrl_reg.speed))
    else $error("Forced speed not applied with negotiation off.");

  a_negotiated_mode: assert property (ctrl_reg.an |=>
    port_speed_100 == $past(an_speed_100) && port_full_duplex == $past(an_full_duplex))
    else $error("Forced bits affected the port while negotiating.");

  a_forced_duplex: assert property (!ctrl_reg.an |=> port_full_duplex == $past(ctrl_reg.duplex))
    else $error("Forced duplex not applied with negotiation off.");

  a_power_down_write: assert property (s_plain_write |=>
    port_power_down == $past(reg_wdata[POWER_DOWN_BIT]))
    else $error("Power-down bit did not follow the write.");

  a_an_complete_set: assert property (autoneg_done && ctrl_reg.an && !ctrl_reg.pd
    && ctrl_reg.loaded |=> autoneg_complete)
    else $error("Negotiation completion was not flagged.");

  a_restart_pulse: assert property (s_plain_write ##0 reg_wdata[RESTART_BIT] ##1 !ctrl_wr
    |-> autoneg_restart_pulse ##1 !autoneg_restart_pulse)
    else $error("Restart bit did not pulse for exactly one cycle.");

  a_soft_reset_clear: assert property (s_soft_reset_write ##1 !ctrl_wr |->
    ctrl_reg.soft_rst && !port_power_down && !ctrl_reg.loopback ##1 !ctrl_reg.soft_rst)
    else $error("Soft reset did not restore defaults and self-clear.");

  a_speed_default: assert property (s_soft_reset_write |=>
    ctrl_reg.speed == (autoneg_strap | speed_strap))
    else $error("Speed default differs from strap combination.");

  a_an_default: assert property (s_soft_reset_write |=> autoneg_enable == autoneg_strap)
    else $error("Negotiation default differs from strap.");

  a_duplex_default: assert property (s_soft_reset_write |=>
    ctrl_reg.duplex == (!autoneg_strap & duplex_strap))
    else $error("Duplex default differs from strap combination.");

  a_reserved_zero: assert property (reg_rd_en && reg_index == CTRL_INDEX |=>
    reg_rd_valid && reg_rdata[10] == 1'b0 && reg_rdata[6:0] == 7'h00)
    else $error("Reserved control bits did not read as zero.");

endmodule

/* File: test_phy_basic_control_register.sv */
// Self-checking bench for the port transceiver basic control register.
// Assumes mgmt_host drives the register port; every other input is driven here.
`timescale 1ns/1ps
module test_phy_basic_control_register;
  import port_ctrl_pkg::*;
  logic        sys_clk = 1'b0, reset_n = 1'b0;
  logic        autoneg_strap = 1'b0, speed_strap = 1'b0, duplex_strap = 1'b0;
  logic        autoneg_done = 1'b0, an_speed_100 = 1'b0, an_full_duplex = 1'b0;
  logic        fab_tx_en = 1'b0, net_rx_dv = 1'b0, net_col = 1'b0;
  logic [3:0]  fab_txd = 4'h0, net_rxd = 4'h0, net_txd, fab_rxd;
  logic        reg_wr_en, reg_rd_en, reg_rd_valid, autoneg_enable, autoneg_restart_pulse;
  logic        autoneg_complete, port_power_down, port_speed_100, port_full_duplex;
  logic        net_tx_en, fab_rx_dv, fab_col;
  logic [4:0]  reg_index;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [15:0] exp_q[$];
  logic [2:0]  s;
  int          n_errors = 0, checks = 0;

  always #4 sys_clk = ~sys_clk;

  mgmt_host u_host (.sys_clk, .reg_wr_en, .reg_rd_en, .reg_index, .reg_wdata);
  port_transceiver_control u_dut (
    .sys_clk, .reset_n, .autoneg_strap, .speed_strap, .duplex_strap, .reg_wr_en, .reg_rd_en,
    .reg_index, .reg_wdata, .autoneg_done, .an_speed_100, .an_full_duplex, .fab_tx_en,
    .fab_txd, .net_rx_dv, .net_rxd, .net_col, .reg_rdata, .reg_rd_valid, .autoneg_enable,
    .autoneg_restart_pulse, .autoneg_complete, .port_power_down, .port_speed_100,
    .port_full_duplex, .net_tx_en, .net_txd, .fab_rx_dv, .fab_rxd, .fab_col);

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bit_chk(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask

  task automatic wr(input logic [15:0] data);
    u_host.access(1'b1, CTRL_INDEX, data);
  endtask

  task automatic rd(input logic [4:0] idx, input logic [15:0] exp);
    exp_q.push_back(exp);
    u_host.access(1'b0, idx, 16'h0000);
  endtask

  task automatic tally_and_finish;
    if (exp_q.size() != 0) n_errors++;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Each read answer is compared with the oldest expectation left by the driver.
  // The answer is sampled at the falling edge, where it has settled.
  always @(negedge sys_clk) begin
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("unrequested read", 16'h0000, 16'hffff);
      else chk("read data", exp_q.pop_front(), reg_rdata);
    end
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h2155));
    repeat (4) @(negedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      s = 3'(i);
      {autoneg_strap, speed_strap, duplex_strap} = s;
      wr(16'h8000);
      bit_chk("negotiation default", s[2], autoneg_enable);
      rd(CTRL_INDEX, {2'b00, s[2] | s[1], s[2], 3'b000, !s[2] & s[0], 8'h00});
    end
    {autoneg_strap, speed_strap, duplex_strap} = 3'b000;
    wr(16'h8000);
    $display("test strap defaults ended");
    for (int i = 0; i < 4; i++) begin
      d = (i == 0) ? 16'h65ff : 16'($urandom) & 16'h65ff;
      wr(d);
      @(negedge sys_clk);
      bit_chk("forced speed", d[13], port_speed_100);
      bit_chk("forced duplex", d[8], port_full_duplex);
      rd(CTRL_INDEX, d & 16'h6180);
    end
    $display("test forced modes ended");
    an_speed_100 = 1'($urandom);
    an_full_duplex = 1'($urandom);
    d = {2'b00, !an_speed_100, 1'b1, 3'b000, !an_full_duplex, 8'h00};
    wr(d);
    @(negedge sys_clk);
    bit_chk("negotiated speed", an_speed_100, port_speed_100);
    bit_chk("negotiated duplex", an_full_duplex, port_full_duplex);
    bit_chk("negotiation enable", 1'b1, autoneg_enable);
    autoneg_done = 1'b1;
    @(negedge sys_clk);
    autoneg_done = 1'b0;
    bit_chk("negotiation complete", 1'b1, autoneg_complete);
    rd(STATUS_INDEX, 16'h0020);
    wr(d | 16'h0200);
    bit_chk("restart pulse", 1'b1, autoneg_restart_pulse);
    bit_chk("complete after restart", 1'b0, autoneg_complete);
    @(negedge sys_clk);
    bit_chk("restart pulse end", 1'b0, autoneg_restart_pulse);
    rd(CTRL_INDEX, d);
    $display("test negotiation ended");
    wr(16'h0000);
    wr(16'h0800);
    bit_chk("power down", 1'b1, port_power_down);
    fab_tx_en = 1'b1;
    fab_txd = 4'($urandom);
    @(negedge sys_clk);
    bit_chk("tx gated", 1'b0, net_tx_en);
    wr(16'h0000);
    bit_chk("power up", 1'b0, port_power_down);
    net_rx_dv = 1'b1;
    net_rxd = 4'($urandom);
    @(negedge sys_clk);
    bit_chk("tx enable", 1'b1, net_tx_en);
    chk("tx data", {12'h000, fab_txd}, {12'h000, net_txd});
    chk("rx data", {12'h000, net_rxd}, {12'h000, fab_rxd});
    $display("test power down ended");
    wr(16'h4100);
    fab_txd = ~net_rxd;
    @(negedge sys_clk);
    bit_chk("loop tx blocked", 1'b0, net_tx_en);
    bit_chk("loop rx valid", 1'b1, fab_rx_dv);
    chk("loop data", {12'h000, fab_txd}, {12'h000, fab_rxd});
    wr(16'h4180);
    @(negedge sys_clk);
    bit_chk("test collision", 1'b1, fab_col);
    fab_tx_en = 1'b0;
    @(negedge sys_clk);
    bit_chk("collision idle", 1'b0, fab_col);
    wr(16'h8000);
    u_host.access(1'b1, STATUS_INDEX, 16'hffff);
    rd(CTRL_INDEX, 16'h0000);
    rd(5'h07, 16'h0000);
    $display("test loopback ended");
    repeat (3) @(negedge sys_clk);
    tally_and_finish();
  end
endmodule
